// ### sld_step_loss.sv
`timescale 1ns/1ns
`default_nettype none
module sld_step_loss
  import sld_pkg::*;
#(
  parameter int unsigned REF_TICK_CYC_P = REF_TICK_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Pulse generator side
  input  wire logic        cmd_pulse_i,
  input  wire logic        cmd_dir_up_i,
  output logic             stop_immediate_o,
  output logic             stop_decel_o,
  output logic             preset_shift_o,
  // Encoder and pulser pins
  input  wire logic        feedback_phase_a_i,
  input  wire logic        feedback_phase_b_i,
  input  wire logic        pulser_phase_a_i,
  input  wire logic        pulser_phase_b_i,
  output logic             feedback_phase_a_level_o,
  // Compare output and interrupt
  output logic             compare_three_output_pin_o,
  output logic             irq_o
);

  // ****************************************************
  // Pin synchronisers and feedback filter
  // ****************************************************
  logic [3:0]  pin_raw;
  logic [3:0]  meta_reg;
  logic [3:0]  sync_reg;
  logic [3:0]  level;
  logic [3:0]  level_prev_reg;
  logic [31:0] fb_env_reg;
  logic [31:0] cnt_env_reg;
  logic [31:0] cmp_env_reg;
  logic [31:0] cmp_val_reg;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        filt_bypass;

  assign pin_raw     = {feedback_phase_a_i, feedback_phase_b_i, pulser_phase_a_i, pulser_phase_b_i};
  assign filt_bypass = fb_env_reg[FB_FILT_BIT];

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg       <= 4'h0;
      sync_reg       <= 4'h0;
      level_prev_reg <= 4'h0;
    end else begin
      meta_reg       <= pin_raw;
      sync_reg       <= meta_reg;
      level_prev_reg <= level;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_filt
      logic [5:0] stable_reg;
      logic       filt_bit_reg;
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          stable_reg   <= 6'h00;
          filt_bit_reg <= 1'b0;
        end else if (sync_reg[gi] == filt_bit_reg) begin
          stable_reg <= 6'h00;
        end else if (stable_reg == 6'(FILT_CYC - 1)) begin
          // Short glitches reset the run and never reach the decoder
          stable_reg   <= 6'h00;
          filt_bit_reg <= sync_reg[gi];
        end else begin
          stable_reg <= stable_reg + 6'h01;
        end
      end
      // Pulser lines are never filtered
      assign level[gi] = (gi >= 2 && !filt_bypass) ? filt_bit_reg : sync_reg[gi];
    end
  endgenerate

  // Phase A stays an ordinary input even while counting from it is off
  assign feedback_phase_a_level_o = sync_reg[3];

  // ****************************************************
  // Decoding
  // ****************************************************
  sld_step_type fb_step;
  sld_step_type pul_step;
  logic         fb_en;
  logic         fb_up;
  logic         fb_dn;
  logic         fb_keep_dir;
  logic         simul_err;

  assign fb_step     = sld_decode(level_prev_reg[3:2], level[3:2],
                                  sld_fb_mode_type'(fb_env_reg[FB_TYPE_LSB +: 2]));
  assign pul_step    = sld_decode(level_prev_reg[1:0], level[1:0], FB_QUAD1);
  assign fb_en       = !fb_env_reg[FB_DIS_BIT];
  assign fb_keep_dir = fb_env_reg[FB_DIR_BIT];
  // A 0 in the direction bit swaps the count direction
  assign fb_up       = fb_en & (fb_keep_dir ? fb_step.up : fb_step.dn);
  assign fb_dn       = fb_en & (fb_keep_dir ? fb_step.dn : fb_step.up);
  // Flagged only; motion is left alone
  assign simul_err   = fb_en & fb_step.both;

  // ****************************************************
  // Reference tick (40 MHz / 4096)
  // ****************************************************
  logic [31:0] ref_cnt_reg;
  logic        ref_tick;

  assign ref_tick = (ref_cnt_reg == 32'(REF_TICK_CYC_P - 1));

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_cnt_reg <= 32'h0000_0000;
    end else begin
      ref_cnt_reg <= ref_tick ? 32'h0000_0000 : ref_cnt_reg + 32'h0000_0001;
    end
  end

  // ****************************************************
  // Counter three
  // ****************************************************
  logic [2:0]  cnt_src;
  logic [1:0]  cmp_sel;
  logic [3:0]  cmp_cond;
  logic [1:0]  cmp_act;
  logic        cmd_up;
  logic        cmd_dn;
  logic        src_up;
  logic        src_dn;
  logic [2:0]  delta;
  logic        idx_mode;
  logic        step_up;
  logic        step_dn;
  logic [31:0] idx_lim;
  logic        wrap_up;
  logic        wrap_dn;
  logic        idx_pulse;
  logic        clear_cmd;

  assign cnt_src  = cnt_env_reg[CNT_SRC_LSB +: 3];
  assign cmp_sel  = cmp_env_reg[CMP_SEL_LSB +: 2];
  assign cmp_cond = cmp_env_reg[CMP_COND_LSB +: 4];
  assign cmp_act  = cmp_env_reg[CMP_ACT_LSB +: 2];
  assign cmd_up   = cmd_pulse_i & cmd_dir_up_i;
  assign cmd_dn   = cmd_pulse_i & !cmd_dir_up_i;

  // Single-step sources
  assign src_up = (cnt_src == SRC_CMD    & cmd_up) |
                  (cnt_src == SRC_FB     & fb_up) |
                  (cnt_src == SRC_PULSER & pul_step.up) |
                  (cnt_src == SRC_REF    & ref_tick);
  assign src_dn = (cnt_src == SRC_CMD    & cmd_dn) |
                  (cnt_src == SRC_FB     & fb_dn) |
                  (cnt_src == SRC_PULSER & pul_step.dn);

  // Deviation: command pulses add, feedback pulses subtract
  assign delta = (cnt_src == SRC_DEV) ?
                 3'(cmd_up) + 3'(fb_dn) - 3'(cmd_dn) - 3'(fb_up) :
                 3'(src_up) - 3'(src_dn);

  assign idx_mode = (cmp_sel == SEL_CNT3) &&
                    (cmp_cond == COND_IDX_BI || cmp_cond == COND_IDX_UP || cmp_cond == COND_IDX_DN);
  assign step_up  = !delta[2] && (delta != 3'b000);
  assign step_dn  = delta[2];
  assign idx_lim  = {17'h0_0000, cmp_val_reg[INDEX_MAX_W-1:0]};
  assign wrap_up  = idx_mode & step_up & (cnt_reg >= idx_lim);
  assign wrap_dn  = idx_mode & step_dn & (cnt_reg == 32'h0000_0000);
  assign idx_pulse = (wrap_up & (cmp_cond != COND_IDX_DN)) |
                     (wrap_dn & (cmp_cond != COND_IDX_UP));

  always_comb begin
    if (clear_cmd) begin
      cnt_next = 32'h0000_0000;
    end else if (idx_mode) begin
      if (wrap_up) begin
        cnt_next = 32'h0000_0000;
      end else if (wrap_dn) begin
        cnt_next = idx_lim;
      end else if (step_up) begin
        cnt_next = cnt_reg + 32'h0000_0001;
      end else if (step_dn) begin
        cnt_next = cnt_reg - 32'h0000_0001;
      end else begin
        cnt_next = cnt_reg;
      end
    end else begin
      cnt_next = cnt_reg + {{29{delta[2]}}, delta};
    end
  end

  // ****************************************************
  // Comparator three and actions
  // ****************************************************
  logic met_lvl;
  logic met_prev_reg;
  logic met_evt;
  logic stop_imm_reg;
  logic stop_decel_reg;
  logic preset_reg;
  logic pin_reg;

  assign met_lvl = (cmp_sel == SEL_CNT3) && (cmp_cond == COND_GT) &&
                   ($signed(cnt_reg) > $signed(cmp_val_reg));
  assign met_evt = idx_mode ? idx_pulse : (met_lvl & !met_prev_reg);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg        <= REG_RESET;
      met_prev_reg   <= 1'b0;
      stop_imm_reg   <= 1'b0;
      stop_decel_reg <= 1'b0;
      preset_reg     <= 1'b0;
      pin_reg        <= 1'b0;
    end else begin
      cnt_reg        <= cnt_next;
      met_prev_reg   <= met_lvl;
      stop_imm_reg   <= met_evt & (cmp_act == ACT_STOP);
      stop_decel_reg <= met_evt & (cmp_act == ACT_DECEL);
      preset_reg     <= met_evt & (cmp_act == ACT_PRESET);
      pin_reg        <= idx_mode ? idx_pulse : met_lvl;
    end
  end

  assign stop_immediate_o           = stop_imm_reg;
  assign stop_decel_o               = stop_decel_reg;
  assign preset_shift_o             = preset_reg;
  assign compare_three_output_pin_o = pin_reg;

  // ****************************************************
  // APB slave and registers
  // ****************************************************
  logic        acc_wr;
  logic        acc_rd;
  logic        hit;
  logic [31:0] rd_mux;
  logic [31:0] err_stat_reg;
  logic [31:0] irq_stat_reg;
  logic [31:0] irq_mask_reg;
  logic [31:0] irq_set;
  logic [31:0] err_set;

  assign hit = (paddr_i == OFS_FB_ENV)   | (paddr_i == OFS_CNT_ENV)  | (paddr_i == OFS_CMP_ENV) |
               (paddr_i == OFS_ERR_STAT) | (paddr_i == OFS_CMP_VAL)  | (paddr_i == OFS_CNT_VAL) |
               (paddr_i == OFS_COMMAND)  | (paddr_i == OFS_IRQ_STAT) | (paddr_i == OFS_IRQ_MASK);
  assign acc_wr    = psel_i & penable_i & pwrite_i & hit;
  assign acc_rd    = psel_i & !penable_i & !pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & !hit;
  assign clear_cmd = acc_wr & (paddr_i == OFS_COMMAND) & (pwdata_i[15:0] == CLEAR_CNT3_CMD);

  assign rd_mux = (paddr_i == OFS_FB_ENV)   ? fb_env_reg :
                  (paddr_i == OFS_CNT_ENV)  ? cnt_env_reg :
                  (paddr_i == OFS_CMP_ENV)  ? cmp_env_reg :
                  (paddr_i == OFS_ERR_STAT) ? err_stat_reg :
                  (paddr_i == OFS_CMP_VAL)  ? cmp_val_reg :
                  (paddr_i == OFS_CNT_VAL)  ? cnt_reg :
                  (paddr_i == OFS_IRQ_STAT) ? irq_stat_reg :
                  (paddr_i == OFS_IRQ_MASK) ? irq_mask_reg : 32'h0000_0000;

  // Sticky sets beat a same-cycle write-one clear
  assign irq_set = (32'(met_evt) << IRQ_CMP3_BIT) | (32'(simul_err) << IRQ_ERR_BIT);
  assign err_set = 32'(simul_err) << ERR_SIMUL_BIT;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fb_env_reg  <= REG_RESET;
      cnt_env_reg <= REG_RESET;
      cmp_env_reg <= REG_RESET;
      cmp_val_reg <= REG_RESET;
      irq_mask_reg <= REG_RESET;
    end else if (acc_wr) begin
      if (paddr_i == OFS_FB_ENV)   fb_env_reg   <= pwdata_i;
      if (paddr_i == OFS_CNT_ENV)  cnt_env_reg  <= pwdata_i;
      if (paddr_i == OFS_CMP_ENV)  cmp_env_reg  <= pwdata_i;
      if (paddr_i == OFS_CMP_VAL)  cmp_val_reg  <= pwdata_i;
      if (paddr_i == OFS_IRQ_MASK) irq_mask_reg <= pwdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      err_stat_reg <= REG_RESET;
      irq_stat_reg <= REG_RESET;
      prdata_o     <= REG_RESET;
    end else begin
      err_stat_reg <= (err_stat_reg & ~((acc_wr && paddr_i == OFS_ERR_STAT) ? pwdata_i : 32'h0)) | err_set;
      irq_stat_reg <= (irq_stat_reg & ~((acc_wr && paddr_i == OFS_IRQ_STAT) ? pwdata_i : 32'h0)) | irq_set;
      if (acc_rd) begin
        prdata_o <= rd_mux;
      end
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence one_cycle_pulse(sig);
    sig ##1 !sig;
  endsequence

  sequence quiet_count;
    !clear_cmd && !idx_mode && cnt_src == SRC_DEV;
  endsequence

  clear_counter_a: assert property (clear_cmd |=> cnt_reg == 32'h0)
    else $error("counter three not cleared by command");
  simul_flag_a: assert property (simul_err |=> err_stat_reg[ERR_SIMUL_BIT] && irq_stat_reg[IRQ_ERR_BIT])
    else $error("simultaneous phase change not flagged");
  simul_nostop_a: assert property (simul_err && !met_evt |=> !stop_immediate_o && !stop_decel_o)
    else $error("simultaneous phase change stopped motion");
  dev_count_a: assert property (quiet_count and (cmd_up && !fb_up && !fb_dn)
                                |=> cnt_reg == $past(cnt_reg) + 32'h1)
    else $error("deviation counter missed a command pulse");
  fb_disable_a: assert property (fb_env_reg[FB_DIS_BIT] && cnt_src == SRC_FB && !clear_cmd
                                 |=> $stable(cnt_reg))
    else $error("disabled feedback still counted");
  wrap_up_a: assert property (wrap_up && !clear_cmd |=> cnt_reg == 32'h0)
    else $error("index counter did not wrap to zero");
  wrap_down_a: assert property (wrap_dn && !clear_cmd |=> cnt_reg == $past(idx_lim))
    else $error("index counter did not wrap to limit");
  index_pin_a: assert property (idx_pulse |=> one_cycle_pulse(compare_three_output_pin_o) or
                                compare_three_output_pin_o ##1 compare_three_output_pin_o)
    else $error("index pulse missing on compare pin");
  idx_dir_a: assert property (cmp_cond == COND_IDX_UP && wrap_dn |=> !compare_three_output_pin_o)
    else $error("index pulse in excluded direction");
  stop_imm_a: assert property (met_evt && cmp_act == ACT_STOP |=> stop_immediate_o && !stop_decel_o)
    else $error("immediate stop not issued");
  dev_met_a: assert property ($rose(met_lvl) && !idx_mode |-> ##[1:2] irq_stat_reg[IRQ_CMP3_BIT])
    else $error("step loss not reported");
  irq_cmp3_a: assert property (met_evt && irq_mask_reg[IRQ_CMP3_BIT] |=> irq_o)
    else $error("comparator three interrupt not raised");
  filt_change_a: assert property (!filt_bypass && $stable(filt_bypass) && $changed(level[3])
                                  |-> $past(g_filt[3].stable_reg) == 6'(FILT_CYC - 1))
    else $error("feedback edge passed the filter too early");
  ref_tick_a: assert property (cnt_src == SRC_REF && !idx_mode && !clear_cmd && ref_tick
                               |=> cnt_reg == $past(cnt_reg) + 32'h1)
    else $error("reference tick not counted");
  pulser_count_a: assert property (cnt_src == SRC_PULSER && !idx_mode && !clear_cmd && pul_step.dn
                                   |=> cnt_reg == $past(cnt_reg) - 32'h1)
    else $error("pulser step not counted");

endmodule : sld_step_loss
`default_nettype wire

// ### sld_pkg.sv
// Notes on behaviour
// - Counter three tracks command pulses against encoder feedback and flags step loss past the stored limit.
// - A step-loss detection triggers the action chosen in the comparator-three action field.
// - Writing the clear command code sets counter three to zero, also in deviation use.
// - The feedback input type selects quadrature 1x, 2x, 4x or separate up and down pulse lines.
// - A change of both feedback phases in one clock sets the error status and interrupt but never stops motion.
// - Counter source 100 counts output pulses minus encoder feedback pulses.
// - Counter sources 000, 001, 010 and 011 count command pulses, feedback, pulser or a 40 MHz/4096 tick.
// - The direction control bit reverses feedback counting when 0 and leaves it unchanged when 1.
// - With the filter bit at 0 feedback pulses shorter than 150 ns are ignored; at 1 the filter is bypassed.
// - With the disable bit at 1 feedback is not counted, while phase A stays readable as an input.
// - Comparing counter three (select 10) under an index code drives periodic pulses on the compare pin.
// - Index code 1000 pulses in both directions, 1001 only counting up, 1010 only counting down.
// - In index mode counter three wraps between zero and the compare value, at most 32767.
// - For step-loss use the condition holds while counter three is greater than the compare value.
// - With interrupt enable bit 7 set, a met comparator-three condition raises the interrupt.
// - Action code 01 stops at once and 10 decelerates then stops.
package sld_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned CLK_NS       = 4;
  localparam int unsigned FILT_NS      = 150;
  localparam int unsigned FILT_CYC     = (FILT_NS + CLK_NS - 1) / CLK_NS;
  // One period of 40 MHz divided by 4096
  localparam int unsigned REF_TICK_NS  = 102400;
  localparam int unsigned REF_TICK_CYC = REF_TICK_NS / CLK_NS;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0]  OFS_FB_ENV     = 8'h00;
  localparam logic [7:0]  OFS_CNT_ENV    = 8'h04;
  localparam logic [7:0]  OFS_CMP_ENV    = 8'h08;
  localparam logic [7:0]  OFS_ERR_STAT   = 8'h0c;
  localparam logic [7:0]  OFS_CMP_VAL    = 8'h10;
  localparam logic [7:0]  OFS_CNT_VAL    = 8'h14;
  localparam logic [7:0]  OFS_COMMAND    = 8'h18;
  localparam logic [7:0]  OFS_IRQ_STAT   = 8'h1c;
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h20;
  localparam logic [31:0] REG_RESET      = 32'h0000_0000;
  localparam logic [15:0] CLEAR_CNT3_CMD = 16'h0022;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int unsigned FB_TYPE_LSB   = 8;
  localparam int unsigned FB_DIR_BIT    = 10;
  localparam int unsigned FB_FILT_BIT   = 11;
  localparam int unsigned FB_DIS_BIT    = 17;
  localparam int unsigned CNT_SRC_LSB   = 12;
  localparam int unsigned CMP_SEL_LSB   = 16;
  localparam int unsigned CMP_COND_LSB  = 18;
  localparam int unsigned CMP_ACT_LSB   = 22;
  localparam int unsigned ERR_SIMUL_BIT = 13;
  localparam int unsigned IRQ_ERR_BIT   = 0;
  localparam int unsigned IRQ_CMP3_BIT  = 7;
  localparam int unsigned INDEX_MAX_W   = 15;

  // ****************************************************
  // Encodings
  // ****************************************************
  typedef enum logic [1:0] {
    FB_QUAD1 = 2'b00, FB_QUAD2 = 2'b01, FB_QUAD4 = 2'b10, FB_TWO_PULSE = 2'b11
  } sld_fb_mode_type;
  localparam logic [2:0] SRC_CMD     = 3'b000;
  localparam logic [2:0] SRC_FB      = 3'b001;
  localparam logic [2:0] SRC_PULSER  = 3'b010;
  localparam logic [2:0] SRC_REF     = 3'b011;
  localparam logic [2:0] SRC_DEV     = 3'b100;
  localparam logic [1:0] SEL_CNT3    = 2'b10;
  localparam logic [3:0] COND_GT     = 4'b0101;
  localparam logic [3:0] COND_IDX_BI = 4'b1000;
  localparam logic [3:0] COND_IDX_UP = 4'b1001;
  localparam logic [3:0] COND_IDX_DN = 4'b1010;
  localparam logic [1:0] ACT_STOP    = 2'b01;
  localparam logic [1:0] ACT_DECEL   = 2'b10;
  localparam logic [1:0] ACT_PRESET  = 2'b11;

  typedef struct packed {
    logic up;
    logic dn;
    logic both;
  } sld_step_type;

  // Phases packed as {a, b}
  function automatic sld_step_type sld_decode(input logic [1:0] prev, input logic [1:0] cur,
                                              input sld_fb_mode_type mode);
    sld_step_type s;
    logic         a_chg;
    logic         b_chg;
    a_chg  = prev[1] ^ cur[1];
    b_chg  = prev[0] ^ cur[0];
    s.both = a_chg & b_chg;
    s.up   = 1'b0;
    s.dn   = 1'b0;
    if (!s.both) begin
      unique case (mode)
        FB_QUAD1: begin
          s.up = a_chg & cur[1] & !cur[0];
          s.dn = a_chg & !cur[1] & !cur[0];
        end
        FB_QUAD2: begin
          s.up = a_chg & (cur[1] ^ cur[0]);
          s.dn = a_chg & !(cur[1] ^ cur[0]);
        end
        FB_QUAD4: begin
          s.up = (a_chg & (cur[1] ^ cur[0])) | (b_chg & !(cur[1] ^ cur[0]));
          s.dn = (a_chg & !(cur[1] ^ cur[0])) | (b_chg & (cur[1] ^ cur[0]));
        end
        FB_TWO_PULSE: begin
          s.up = a_chg & cur[1];
          s.dn = b_chg & cur[0];
        end
      endcase
    end
    return s;
  endfunction : sld_decode

endpackage : sld_pkg

// ### sld_enc_model.sv
`timescale 1ns/1ns
`default_nettype none
module sld_enc_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Requests: up, down, both phases, phase a only
  input  wire logic [3:0] ctl_i,
  // Encoder pins, always driven
  output logic            phase_a_o,
  output logic            phase_b_o
);
  logic [1:0] ph_reg = 2'h0;
  // Phase a leads b when stepping up
  always @(posedge sys_clk_i) begin
    if (ctl_i[3]) ph_reg <= {~ph_reg[0], ph_reg[1]};
    else if (ctl_i[2]) ph_reg <= {ph_reg[0], ~ph_reg[1]};
    else if (ctl_i[1]) ph_reg <= ~ph_reg;
    else if (ctl_i[0]) ph_reg <= {~ph_reg[1], ph_reg[0]};
  end
  assign phase_a_o = ph_reg[1];
  assign phase_b_o = ph_reg[0];
endmodule : sld_enc_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sld_pkg::*;
  logic        clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, cmd = 1'h0, dir_up = 1'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [3:0]  ectl = 4'h0;
  logic        to_pul = 1'h0;
  logic        pready, pslverr, rd_err, s_imm, s_dec, s_pre, fa, fb, pa, pb, fa_lvl, pin, irq;
  int          miscompares = 0, total_checks = 0, n_stop = 0, n_dec = 0, n_pin = 0, n_pre = 0, i, e, lim, ns, nd, np;
  logic [1:0]  act;
  always #2 clk = ~clk;
  sld_step_loss #(.REF_TICK_CYC_P(16)) dut_u (.sys_clk_i(clk), .resetn_i(rstn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .cmd_pulse_i(cmd), .cmd_dir_up_i(dir_up),
    .stop_immediate_o(s_imm), .stop_decel_o(s_dec), .preset_shift_o(s_pre), .feedback_phase_a_i(fa),
    .feedback_phase_b_i(fb), .pulser_phase_a_i(pa), .pulser_phase_b_i(pb),
    .feedback_phase_a_level_o(fa_lvl), .compare_three_output_pin_o(pin), .irq_o(irq));
  // One stimulus channel, steered to the encoder or to the manual pulser
  sld_enc_model enc_u (.sys_clk_i(clk), .ctl_i(to_pul ? 4'h0 : ectl), .phase_a_o(fa), .phase_b_o(fb));
  sld_enc_model pul_u (.sys_clk_i(clk), .ctl_i(to_pul ? ectl : 4'h0), .phase_a_o(pa), .phase_b_o(pb));
  // ****************************************************
  // Helpers
  // ****************************************************
  always @(posedge clk) begin
    if (s_imm === 1'h1) n_stop++;
    if (s_dec === 1'h1) n_dec++;
    if (pin === 1'h1) n_pin++;
    if (s_pre === 1'h1) n_pre++;
  end
  task end_of_test;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'h1) break;
    end
    if (n == 16) begin
      miscompares++;
      end_of_test();
    end
    rd_q = prdata;
    rd_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask : rd
  task clr;
    wr(OFS_COMMAND, {16'h0, CLEAR_CNT3_CMD});
  endtask : clr
  task pulses(input int n, input logic up);
    repeat (n) begin
      @(posedge clk);
      cmd <= 1'h1;
      dir_up <= up;
      @(posedge clk);
      cmd <= 1'h0;
    end
    repeat (3) @(posedge clk);
  endtask : pulses
  task enc(input logic [3:0] c, input int gap);
    @(posedge clk);
    ectl <= c;
    @(posedge clk);
    ectl <= 4'h0;
    repeat (gap) @(posedge clk);
  endtask : enc
  function automatic logic [31:0] fbcfg(input int m, input int dr, input int byp, input int dis);
    return 32'((m << FB_TYPE_LSB) | (dr << FB_DIR_BIT) | (byp << FB_FILT_BIT) | (dis << FB_DIS_BIT));
  endfunction : fbcfg
  function automatic logic [31:0] quad_exp(input int m, input int dr, input int n);
    int c;
    c = (m == 0) ? n / 4 : (m == 1) ? n / 2 : n;
    return 32'(dr != 0 ? c : -c);
  endfunction : quad_exp
  function automatic logic [31:0] cmpcfg(input logic [1:0] ac, input logic [3:0] cd);
    return (32'(ac) << CMP_ACT_LSB) | (32'(cd) << CMP_COND_LSB) | (32'(SEL_CNT3) << CMP_SEL_LSB);
  endfunction : cmpcfg
  // ****************************************************
  // Scenarios
  // ****************************************************
  initial begin
    void'($urandom(29021));
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    rd(OFS_CNT_VAL);
    chk(rd_q, REG_RESET);
    chk({31'h0, irq}, 32'h0);
    rd(8'hfc);
    chk({31'h0, rd_err}, 32'h1);
    wr(OFS_CNT_ENV, {17'h0, SRC_FB, 12'h0});
    // Multiples of four edges bring the encoder back to phase 00
    for (i = 0; i < 6; i++) begin
      wr(OFS_FB_ENV, fbcfg(i % 3, i / 3, 1, 0));
      clr();
      e = 4 * (1 + $urandom % 3);
      // Odd passes step up, even passes step down
      np = i % 2;
      repeat (e) enc(np != 0 ? 4'h8 : 4'h4, 5);
      rd(OFS_CNT_VAL);
      chk(rd_q, quad_exp(i % 3, int'(i / 3 == np), e));
    end
    wr(OFS_FB_ENV, fbcfg(2, 1, 1, 1));
    clr();
    repeat (5) enc(4'h8, 5);
    rd(OFS_CNT_VAL);
    chk(rd_q, 32'h0);
    chk({31'h0, fa_lvl}, 32'h1);
    repeat (3) enc(4'h8, 5);
    // Twelve cycle glitch is below the filter length
    wr(OFS_FB_ENV, fbcfg(3, 1, 0, 0));
    clr();
    enc(4'h1, 10);
    enc(4'h1, 60);
    rd(OFS_CNT_VAL);
    chk(rd_q, 32'h0);
    enc(4'h1, 60);
    enc(4'h1, 60);
    rd(OFS_CNT_VAL);
    chk(rd_q, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_FB_ENV, fbcfg(2, 1, 1, 0));
    ns = n_stop;
    enc(4'h2, 8);
    rd(OFS_ERR_STAT);
    chk({31'h0, rd_q[ERR_SIMUL_BIT]}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    chk(32'(n_stop - ns), 32'h0);
    wr(OFS_ERR_STAT, 32'hffffffff);
    wr(OFS_IRQ_STAT, 32'hffffffff);
    wr(OFS_IRQ_MASK, 32'h80);
    wr(OFS_CNT_ENV, {17'h0, SRC_CMD, 12'h0});
    for (i = 0; i < 3; i++) begin
      lim = 2 + $urandom % 5;
      wr(OFS_CMP_VAL, 32'(lim));
      wr(OFS_CMP_ENV, cmpcfg(2'h0, COND_IDX_BI + 4'(i)));
      clr();
      np = n_pin;
      pulses(lim + 1, 1'h1);
      rd(OFS_CNT_VAL);
      chk(rd_q, 32'h0);
      chk(32'(n_pin - np), 32'(i != 2));
      chk({31'h0, irq}, 32'(i != 2));
      wr(OFS_IRQ_STAT, 32'h80);
      np = n_pin;
      pulses(1, 1'h0);
      rd(OFS_CNT_VAL);
      chk(rd_q, 32'(lim));
      chk(32'(n_pin - np), 32'(i != 1));
      wr(OFS_IRQ_STAT, 32'h80);
    end
    wr(OFS_CNT_ENV, {17'h0, SRC_DEV, 12'h0});
    wr(OFS_CMP_VAL, 32'd32);
    for (i = 0; i < 3; i++) begin
      act = i == 0 ? ACT_STOP : i == 1 ? ACT_DECEL : ACT_PRESET;
      wr(OFS_CMP_ENV, cmpcfg(act, COND_GT));
      clr();
      wr(OFS_IRQ_STAT, 32'h80);
      ns = n_stop;
      nd = n_dec;
      np = n_pre;
      pulses(32, 1'h1);
      chk({31'h0, irq}, 32'h0);
      pulses(1, 1'h1);
      rd(OFS_CNT_VAL);
      chk(rd_q, 32'd33);
      chk(32'(n_stop - ns), 32'(act == ACT_STOP));
      chk(32'(n_dec - nd), 32'(act == ACT_DECEL));
      chk(32'(n_pre - np), 32'(act == ACT_PRESET));
      chk({31'h0, irq}, 32'h1);
      clr();
      rd(OFS_CNT_VAL);
      chk(rd_q, 32'h0);
    end
    // Feedback steps take back command steps
    pulses(5, 1'h1);
    repeat (3) enc(4'h8, 5);
    rd(OFS_CNT_VAL);
    chk(rd_q, 32'd2);
    wr(OFS_CNT_ENV, {17'h0, SRC_PULSER, 12'h0});
    clr();
    to_pul <= 1'h1;
    repeat (8) enc(4'h4, 3);
    rd(OFS_CNT_VAL);
    chk(rd_q, 32'hffff_fffe);
    // Read loads 160 cycles apart span exactly ten ticks of 16 cycles
    wr(OFS_CNT_ENV, {17'h0, SRC_REF, 12'h0});
    rd(OFS_CNT_VAL);
    lim = rd_q;
    repeat (157) @(posedge clk);
    rd(OFS_CNT_VAL);
    chk(rd_q - 32'(lim), 32'd10);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
